// ### core/sic_defs.vh
`ifndef SIC_DEFS_VH
`define SIC_DEFS_VH
// ----------------------------------------
// register offsets, low nibble within a channel; module stop at a full byte address
// ----------------------------------------
`define SIC_OFS_CTRL 4'h0
`define SIC_OFS_STAT 4'h4
`define SIC_OFS_TDATA 4'h8
`define SIC_OFS_RDATA 4'hC
`define SIC_OFS_STOP 8'h30
`define SIC_NUM_CH 2'h3
// ----------------------------------------
// control fields
// ----------------------------------------
`define SIC_C_TE 0
`define SIC_C_RE 1
`define SIC_C_TIE 2
`define SIC_C_RIE 3
`define SIC_C_TRANSMIT_END_INTERRUPT_ENABLE 4
`define SIC_C_SC 5
`define SIC_C_SYNC 6
`define SIC_C_PDIR 7
`define SIC_C_PDAT 8
`define SIC_CTRL_RST 9'h000
// ----------------------------------------
// status fields
// ----------------------------------------
`define SIC_S_OVR 0
`define SIC_S_FER 1
`define SIC_S_PER 2
`define SIC_S_ERS 3
`define SIC_S_RXF 4
`define SIC_S_TRANSMIT_EMPTY_FLAG 5
`define SIC_S_TRANSMIT_END_FLAG 6
`define SIC_STAT_RST 7'h60
`define SIC_STOP_RST 3'h7
// ----------------------------------------
// frame bit counts
// ----------------------------------------
`define SIC_TX_LAST_ASYNC 4'hA
`define SIC_TX_LAST_SC 4'hB
`define SIC_RX_DATA_END 4'h8
`define SIC_RX_PAR 4'h9
`endif

// ### core/sic_sync.v
module sic_sync #(
  parameter W = 6
) (
  input wire clk,
  input wire sys_rst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  // two stages against metastability on pin inputs
  always @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= {W{1'b1}};
      sync_reg <= {W{1'b1}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule

// ### core/sic_chan.v
`include "sic_defs.vh"
module sic_chan (
  input wire clk,
  input wire chanRst,
  input wire sclkRise,
  input wire sclkFall,
  input wire rxd,
  input wire txEnable,
  input wire rxEnable,
  input wire scMode,
  input wire txReady,
  input wire [7:0] tdata,
  output reg txBit,
  output reg txTake,
  output reg txDone,
  output reg txErr,
  output reg rxDone,
  output wire [7:0] rxData,
  output reg rxFerr,
  output reg rxPerr
);
  reg txBusy_reg;
  reg [3:0] txCnt_reg;
  reg [7:0] tsr_reg;
  reg errSeen_reg;
  reg [3:0] rxCnt_reg;
  reg [7:0] rsr_reg;
  reg parBit_reg;
  reg nextBit;
  wire [3:0] txLast;
  wire [3:0] txCntInc;
  assign txLast = scMode ? `SIC_TX_LAST_SC : `SIC_TX_LAST_ASYNC;
  assign txCntInc = txCnt_reg + 4'h1;
  assign rxData = rsr_reg;
  always @* begin
    nextBit = 1'b1;
    if (txCntInc <= 4'h8) begin
      nextBit = tsr_reg[txCntInc[2:0] - 3'h1];
    end else if (txCntInc == 4'h9) begin
      nextBit = ^tsr_reg;
    end
  end
  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  always @(posedge clk) begin
    if (chanRst | ~txEnable) begin
      txBusy_reg <= 1'b0;
      txCnt_reg <= 4'h0;
      txBit <= 1'b1;
      errSeen_reg <= 1'b0;
      txTake <= 1'b0;
      txDone <= 1'b0;
      txErr <= 1'b0;
      tsr_reg <= 8'h00;
    end else begin
      txTake <= 1'b0;
      txDone <= 1'b0;
      txErr <= 1'b0;
      // error signal from the card is sampled in the guard slot
      if (sclkRise & txBusy_reg & scMode & (txCnt_reg == `SIC_TX_LAST_SC) & ~rxd) begin
        errSeen_reg <= 1'b1;
        txErr <= 1'b1;
      end
      if (sclkFall) begin
        if (~txBusy_reg) begin
          if (txReady) begin
            tsr_reg <= tdata;
            txTake <= 1'b1;
            txBusy_reg <= 1'b1;
            txCnt_reg <= 4'h0;
            txBit <= 1'b0;
          end
        end else if (txCnt_reg == txLast) begin
          if (errSeen_reg) begin
            txCnt_reg <= 4'h0;
            txBit <= 1'b0;
            errSeen_reg <= 1'b0;
          end else begin
            txBit <= 1'b1;
            txBusy_reg <= 1'b0;
            txDone <= 1'b1;
          end
        end else begin
          txCnt_reg <= txCntInc;
          txBit <= nextBit;
        end
      end
    end
  end
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  always @(posedge clk) begin
    if (chanRst | ~rxEnable) begin
      rxCnt_reg <= 4'h0;
      rsr_reg <= 8'h00;
      parBit_reg <= 1'b0;
      rxDone <= 1'b0;
      rxFerr <= 1'b0;
      rxPerr <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      if (sclkRise) begin
        if (rxCnt_reg == 4'h0) begin
          // a held-low line restarts a frame each time: break keeps flagging
          if (~rxd) begin
            rxCnt_reg <= 4'h1;
          end
        end else if (rxCnt_reg <= `SIC_RX_DATA_END) begin
          rsr_reg <= {rxd, rsr_reg[7:1]};
          rxCnt_reg <= rxCnt_reg + 4'h1;
        end else if (rxCnt_reg == `SIC_RX_PAR) begin
          parBit_reg <= rxd;
          rxCnt_reg <= rxCnt_reg + 4'h1;
        end else begin
          rxDone <= 1'b1;
          rxFerr <= ~rxd;
          rxPerr <= parBit_reg ^ (^rsr_reg);
          rxCnt_reg <= 4'h0;
        end
      end
    end
  end
endmodule

// ### core/sic_top.v
// Function
// - normal mode: error, receive-full, transmit-empty and transmit-end requests per channel
// - only receive-full and transmit-empty requests may start the transfer controller
// - smart card mode drops the transmit-end request
// - smart card: error from overrun/parity/error-signal; transmit-empty from transmit-end
// - smart card: transmit-empty and transmit-end flags set together, raising request
// - controller write of transmit data clears transmit-empty and transmit-end
// - smart card error: resend same byte, transmit-end stays low meanwhile
// - receive-full raises request; controller read clears the flag
// - receive error sets error flag only, never receive-full
// - module stop is set after reset; registers usable once cleared
// - break keeps the receiver running and framing error sets again
// - transmitter disabled: data pin follows port direction and data bits
// - clearing transmitter enable initializes the transmitter at once
// - synchronous mode: receive errors block transmit; receiver disable keeps them
// - enabling transmitter and its interrupt after stop raises transmit-empty request
// - receiver disable resets receive shift logic; data in flight is lost
`include "sic_defs.vh"
module sic_top (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [2:0] sclkPin,
  input wire [2:0] rxdPin,
  input wire [2:0] tcTxWrite,
  input wire [23:0] tcTxData,
  input wire [2:0] tcRxRead,
  output wire [23:0] tcRxData,
  output wire [2:0] txdOut,
  output wire [2:0] txdOeN,
  output wire [2:0] rxErrReq,
  output wire [2:0] rxFullReq,
  output wire [2:0] txEmptyReq,
  output wire [2:0] txEndReq,
  output wire [2:0] tcTxStart,
  output wire [2:0] tcRxStart
);
  // ----------------------------------------
  // pin synchronisers and clock edges
  // ----------------------------------------
  wire [5:0] pinSync;
  reg [2:0] sclkPrev_reg;
  wire [2:0] sclkRise;
  wire [2:0] sclkFall;
  sic_sync #(
    .W(6)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({rxdPin, sclkPin}),
    .q(pinSync)
  );
  always @(posedge clk) begin
    if (sys_rst) begin
      sclkPrev_reg <= 3'h7;
    end else begin
      sclkPrev_reg <= pinSync[2:0];
    end
  end
  assign sclkRise = pinSync[2:0] & ~sclkPrev_reg;
  assign sclkFall = ~pinSync[2:0] & sclkPrev_reg;
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  reg pready_reg;
  reg pslverr_reg;
  reg [31:0] prdata_reg;
  reg [31:0] rdMux;
  reg [2:0] mstop_reg;
  wire [1:0] chSel;
  wire [3:0] regSel;
  wire addrOk;
  wire isStop;
  wire access;
  wire wrStrobe;
  wire [26:0] ctrlVec;
  wire [20:0] statVec;
  wire [23:0] rdrVec;
  wire [4:0] ctrlBase;
  wire [4:0] statBase;
  wire [4:0] byteBase;
  assign chSel = paddr[5:4];
  assign regSel = paddr[3:0];
  assign isStop = (paddr == `SIC_OFS_STOP);
  assign addrOk = isStop | ((paddr[7:6] == 2'h0) & (chSel < `SIC_NUM_CH) & (paddr[1:0] == 2'h0));
  assign access = psel & penable & ~pready_reg;
  assign wrStrobe = psel & penable & pready_reg & pwrite & addrOk;
  assign ctrlBase = chSel * 5'd9;
  assign statBase = chSel * 5'd7;
  assign byteBase = {chSel, 3'h0};
  always @* begin
    rdMux = 32'h00000000;
    if (isStop) begin
      rdMux = {29'h0, mstop_reg};
    end else if (~addrOk) begin
      rdMux = 32'h00000000;
    end else if (mstop_reg[chSel]) begin
      // stopped channel reads as zero
      rdMux = 32'h00000000;
    end else if (regSel == `SIC_OFS_CTRL) begin
      rdMux = {23'h0, ctrlVec[ctrlBase +: 9]};
    end else if (regSel == `SIC_OFS_STAT) begin
      rdMux = {25'h0, statVec[statBase +: 7]};
    end else if (regSel == `SIC_OFS_RDATA) begin
      rdMux = {24'h0, rdrVec[byteBase +: 8]};
    end else begin
      rdMux = 32'h00000000;
    end
  end
  // one wait state: pready rises in the second access cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= access;
      if (access) begin
        pslverr_reg <= ~addrOk;
        prdata_reg <= pwrite ? 32'h00000000 : rdMux;
      end
    end
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      mstop_reg <= `SIC_STOP_RST;
    end else if (wrStrobe & isStop) begin
      mstop_reg <= pwdata[2:0];
    end
  end
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  // ----------------------------------------
  // channels
  // ----------------------------------------
  wire [2:0] errNext;
  wire [2:0] rxfNext;
  wire [2:0] txeNext;
  wire [2:0] tendNext;
  wire [2:0] txdNext;
  wire [2:0] oeNext;
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_ch
      reg [8:0] ctrl_reg;
      reg [6:0] stat_reg;
      reg [7:0] tdr_reg;
      reg [7:0] rdr_reg;
      wire stop;
      wire chanRst;
      wire hit;
      wire sc;
      wire hold;
      wire txBit;
      wire txTake;
      wire txDone;
      wire txErr;
      wire rxDone;
      wire [7:0] rxData;
      wire rxFerr;
      wire rxPerr;
      assign stop = mstop_reg[i];
      // stop resets shift, data and status registers
      assign chanRst = sys_rst | stop;
      assign hit = wrStrobe & ~isStop & (chSel == i) & ~stop;
      assign sc = ctrl_reg[`SIC_C_SC];
      assign hold = ctrl_reg[`SIC_C_SYNC] & (stat_reg[`SIC_S_OVR] | stat_reg[`SIC_S_FER] | stat_reg[`SIC_S_PER]);
      sic_chan u_chan (
        .clk(clk),
        .chanRst(chanRst),
        .sclkRise(sclkRise[i]),
        .sclkFall(sclkFall[i]),
        .rxd(pinSync[3 + i]),
        .txEnable(ctrl_reg[`SIC_C_TE]),
        .rxEnable(ctrl_reg[`SIC_C_RE]),
        .scMode(sc),
        .txReady(~stat_reg[`SIC_S_TRANSMIT_EMPTY_FLAG] & ~hold),
        .tdata(tdr_reg),
        .txBit(txBit),
        .txTake(txTake),
        .txDone(txDone),
        .txErr(txErr),
        .rxDone(rxDone),
        .rxData(rxData),
        .rxFerr(rxFerr),
        .rxPerr(rxPerr)
      );
      // clears come first so a same-cycle set wins
      always @(posedge clk) begin
        if (chanRst) begin
          ctrl_reg <= `SIC_CTRL_RST;
          stat_reg <= `SIC_STAT_RST;
          tdr_reg <= 8'h00;
          rdr_reg <= 8'h00;
        end else begin
          if (hit & (regSel == `SIC_OFS_CTRL)) begin
            ctrl_reg <= pwdata[8:0];
          end
          if (hit & (regSel == `SIC_OFS_STAT)) begin
            stat_reg <= stat_reg & ~pwdata[6:0];
          end
          if (hit & (regSel == `SIC_OFS_TDATA)) begin
            tdr_reg <= pwdata[7:0];
            stat_reg[`SIC_S_TRANSMIT_EMPTY_FLAG] <= 1'b0;
            stat_reg[`SIC_S_TRANSMIT_END_FLAG] <= 1'b0;
          end else if (tcTxWrite[i]) begin
            tdr_reg <= tcTxData[i*8 +: 8];
            stat_reg[`SIC_S_TRANSMIT_EMPTY_FLAG] <= 1'b0;
            stat_reg[`SIC_S_TRANSMIT_END_FLAG] <= 1'b0;
          end
          if (tcRxRead[i]) begin
            stat_reg[`SIC_S_RXF] <= 1'b0;
          end
          if (txTake & ~sc) begin
            stat_reg[`SIC_S_TRANSMIT_EMPTY_FLAG] <= 1'b1;
          end
          if (txDone & sc) begin
            stat_reg[`SIC_S_TRANSMIT_EMPTY_FLAG] <= 1'b1;
            stat_reg[`SIC_S_TRANSMIT_END_FLAG] <= 1'b1;
          end else if (txDone & stat_reg[`SIC_S_TRANSMIT_EMPTY_FLAG]) begin
            stat_reg[`SIC_S_TRANSMIT_END_FLAG] <= 1'b1;
          end
          // no hardware clear for the error-signal flag
          if (txErr) begin
            stat_reg[`SIC_S_ERS] <= 1'b1;
          end
          if (rxDone) begin
            if (stat_reg[`SIC_S_RXF]) begin
              stat_reg[`SIC_S_OVR] <= 1'b1;
            end else begin
              rdr_reg <= rxData;
              if (rxFerr) begin
                stat_reg[`SIC_S_FER] <= 1'b1;
              end
              if (rxPerr) begin
                stat_reg[`SIC_S_PER] <= 1'b1;
              end
              if (~rxFerr & ~rxPerr) begin
                stat_reg[`SIC_S_RXF] <= 1'b1;
              end
            end
          end
        end
      end
      assign ctrlVec[i*9 +: 9] = ctrl_reg;
      assign statVec[i*7 +: 7] = stat_reg;
      assign rdrVec[i*8 +: 8] = rdr_reg;
      assign tcRxData[i*8 +: 8] = rdr_reg;
      assign errNext[i] = ctrl_reg[`SIC_C_RIE] & (stat_reg[`SIC_S_OVR] | stat_reg[`SIC_S_PER] |
        (sc ? stat_reg[`SIC_S_ERS] : stat_reg[`SIC_S_FER]));
      assign rxfNext[i] = ctrl_reg[`SIC_C_RIE] & stat_reg[`SIC_S_RXF];
      assign txeNext[i] = ctrl_reg[`SIC_C_TIE] &
        (sc ? stat_reg[`SIC_S_TRANSMIT_END_FLAG] : stat_reg[`SIC_S_TRANSMIT_EMPTY_FLAG]);
      assign tendNext[i] = ctrl_reg[`SIC_C_TRANSMIT_END_INTERRUPT_ENABLE] & stat_reg[`SIC_S_TRANSMIT_END_FLAG] & ~sc;
      assign txdNext[i] = ctrl_reg[`SIC_C_TE] ? txBit : ctrl_reg[`SIC_C_PDAT];
      assign oeNext[i] = ctrl_reg[`SIC_C_TE] ? 1'b0 : ~ctrl_reg[`SIC_C_PDIR];
    end
  endgenerate
  // ----------------------------------------
  // request and pin outputs
  // ----------------------------------------
  reg [2:0] rxErrReq_reg;
  reg [2:0] rxFullReq_reg;
  reg [2:0] txEmptyReq_reg;
  reg [2:0] txEndReq_reg;
  reg [2:0] tcTxStart_reg;
  reg [2:0] tcRxStart_reg;
  reg [2:0] txdOut_reg;
  reg [2:0] txdOeN_reg;
  always @(posedge clk) begin
    if (sys_rst) begin
      rxErrReq_reg <= 3'h0;
      rxFullReq_reg <= 3'h0;
      txEmptyReq_reg <= 3'h0;
      txEndReq_reg <= 3'h0;
      tcTxStart_reg <= 3'h0;
      tcRxStart_reg <= 3'h0;
      txdOut_reg <= 3'h7;
      txdOeN_reg <= 3'h7;
    end else begin
      rxErrReq_reg <= errNext;
      rxFullReq_reg <= rxfNext;
      txEmptyReq_reg <= txeNext;
      txEndReq_reg <= tendNext;
      // error and end requests never reach the controller
      tcTxStart_reg <= txeNext;
      tcRxStart_reg <= rxfNext;
      txdOut_reg <= txdNext;
      txdOeN_reg <= oeNext;
    end
  end
  assign rxErrReq = rxErrReq_reg;
  assign rxFullReq = rxFullReq_reg;
  assign txEmptyReq = txEmptyReq_reg;
  assign txEndReq = txEndReq_reg;
  assign tcTxStart = tcTxStart_reg;
  assign tcRxStart = tcRxStart_reg;
  assign txdOut = txdOut_reg;
  assign txdOeN = txdOeN_reg;
endmodule

// ### test/sic_top_checker.sv
// ----------------------------------------
// port checks for the serial unit
// ----------------------------------------
module sic_top_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [2:0] tcTxWrite,
  input wire logic [2:0] tcRxRead,
  input wire logic [2:0] txdOut,
  input wire logic [2:0] txdOeN,
  input wire logic [2:0] rxErrReq,
  input wire logic [2:0] rxFullReq,
  input wire logic [2:0] txEmptyReq,
  input wire logic [2:0] tcTxStart,
  input wire logic [2:0] tcRxStart
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence accessWait;
    psel && penable && !pready;
  endsequence
  sequence answerOnce;
    pready ##1 !pready;
  endsequence
  txStartCopy_a: assert property (tcTxStart == txEmptyReq)
    else $error("tx start differs from request");
  rxStartCopy_a: assert property (tcRxStart == rxFullReq)
    else $error("rx start differs from request");
  apbAnswer_a: assert property (accessWait |=> answerOnce)
    else $error("bus answer late or too long");
  rxClear_a: assert property (tcRxRead[0] |-> ##2 !rxFullReq[0])
    else $error("receive request kept after read");
  txClear_a: assert property (tcTxWrite[0] |-> ##2 !txEmptyReq[0])
    else $error("transmit request kept after write");
  errNotFull_a: assert property ($rose(rxErrReq[0]) |-> !$rose(rxFullReq[0]))
    else $error("error frame raised receive full");
  readyCause_a: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("answer without access");
  resetState_a: assert property (disable iff (1'b0) sys_rst |=> txdOeN == 3'h7 && txdOut == 3'h7 && !pready)
    else $error("outputs not idle after reset");
endmodule
bind sic_top sic_top_checker CHK (.clk, .sys_rst, .psel, .penable, .pready, .tcTxWrite, .tcRxRead, .txdOut,
  .txdOeN, .rxErrReq, .rxFullReq, .txEmptyReq, .tcTxStart, .tcRxStart);

// ### test/sic_peer.sv
// ----------------------------------------
// far-side serial peer, one channel
// ----------------------------------------
module sic_peer (
  output logic sclk,
  output logic rxd,
  input wire logic txd
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock stands high between frames; line idles at mark, driven high
  initial begin
    sclk = 1'b1;
    rxd = 1'b1;
  end
  task automatic frame(input logic [11:0] bits, input int slots, output logic [11:0] seen);
    seen = 12'hFFF;
    #3;
    for (int s = 0; s <= slots; s++) begin
      sclk = 1'b0;
      rxd = (s < slots) ? bits[s] : 1'b1;
      #40 sclk = 1'b1;
      // sample late in the slot, the device answers a few clocks after the edge
      #36 if (s < 12) seen[s] = txd;
      #4;
    end
    rxd = 1'b1;
  endtask
endmodule

// ### test/test_sic_top.sv
module test_sic_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] tcTxWrite, tcRxRead;
  logic [23:0] tcTxData;
  logic [11:0] seen;
  wire [23:0] tcRxData;
  wire [2:0] sclkPin, rxdPin, txdOut, txdOeN, rxErrReq, rxFullReq, txEmptyReq, txEndReq, tcTxStart, tcRxStart;
  wire sclk0, rxd0;
  int miscompares, checks;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  assign sclkPin = {2'b11, sclk0};
  assign rxdPin = {2'b11, rxd0};
  sic_peer PEER (.sclk(sclk0), .rxd(rxd0), .txd(txdOut[0]));
  sic_top DUT (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sclkPin,
    .rxdPin, .tcTxWrite, .tcTxData, .tcRxRead, .tcRxData, .txdOut, .txdOeN, .rxErrReq, .rxFullReq, .txEmptyReq,
    .txEndReq, .tcTxStart, .tcRxStart);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task tcWrite(input logic [7:0] b);
    @(posedge clk);
    tcTxWrite <= 3'h1;
    tcTxData <= {16'h0000, b};
    @(posedge clk);
    tcTxWrite <= 3'h0;
  endtask
  task settle;
    repeat (12) @(posedge clk);
  endtask
  task finish_test;
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    miscompares++;
    finish_test;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, tcTxWrite, tcTxData, tcRxRead} = 1'b1 << 73;
    miscompares = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h0);
    apb(1'b1, 8'h30, 32'h0);
    apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h60);
    apb(1'b0, 8'hC0, 32'h0); chk(err, 1'b1);
    apb(1'b1, 8'h00, 32'h180); settle; chk({txdOeN[0], txdOut[0]}, 2'h1);
    apb(1'b1, 8'h00, 32'h080); settle; chk({txdOeN[0], txdOut[0]}, 2'h0);
    apb(1'b1, 8'h00, 32'h01F); settle; chk({txEmptyReq[0], txEndReq[0], tcTxStart[0], rxErrReq[0]}, 4'hE);
    tcWrite(8'hA5); settle; chk({txEmptyReq[0], txEndReq[0]}, 2'h0);
    // clock held off well past the data write, an early edge would tear the load
    PEER.frame(12'hFFF, 11, seen); settle;
    chk(seen[10:0], {1'b1, ^8'hA5, 8'hA5, 1'b0});
    chk({txEmptyReq[0], txEndReq[0]}, 2'h3);
    PEER.frame({2'b11, ^8'h3C, 8'h3C, 1'b0}, 11, seen); settle;
    chk({rxFullReq[0], tcRxStart[0], tcRxData[7:0]}, 10'h33C);
    @(posedge clk) tcRxRead <= 3'h1;
    @(posedge clk) tcRxRead <= 3'h0;
    settle; chk(rxFullReq[0], 1'b0);
    for (int i = 0; i < 2; i++) begin
      PEER.frame(12'h000, 11, seen); settle;
      chk({rxErrReq[0], rxFullReq[0]}, 2'h2);
      apb(1'b0, 8'h04, 32'h0); chk(rd[1], 1'b1);
      apb(1'b1, 8'h04, 32'h7);
    end
    apb(1'b1, 8'h00, 32'h03D); settle; chk({txEmptyReq[0], txEndReq[0]}, 2'h2);
    tcWrite(8'h5A); settle; chk(txEmptyReq[0], 1'b0);
    PEER.frame(12'h7FF, 12, seen); settle;
    chk(seen[10:0], {1'b1, ^8'h5A, 8'h5A, 1'b0});
    // the resend start bit leaves on the error frame's last falling edge
    chk({rxErrReq[0], txEmptyReq[0], txdOut[0]}, 3'h4);
    apb(1'b0, 8'h04, 32'h0); chk(rd[6:3], 4'h1);
    apb(1'b1, 8'h04, 32'h8);
    PEER.frame(12'hFFF, 11, seen); settle;
    chk(seen, {3'h7, ^8'h5A, 8'h5A});
    apb(1'b0, 8'h04, 32'h0); chk(rd[6:5], 2'h3);
    chk(txEmptyReq[0], 1'b1);
    // synchronous mode: a receive error holds back the transmitter
    apb(1'b1, 8'h00, 32'h047);
    PEER.frame(12'h000, 11, seen);
    settle;
    apb(1'b1, 8'h00, 32'h045);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[1], 1'b1);
    tcWrite(8'hC3);
    settle;
    PEER.frame(12'hFFF, 11, seen);
    settle;
    chk({seen, txEmptyReq[0]}, 13'h1FFE);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h30, 32'h1);
    apb(1'b1, 8'h30, 32'h0);
    apb(1'b1, 8'h00, 32'h005);
    settle;
    chk(txEmptyReq[0], 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h60);
    apb(1'b1, 8'h08, 32'h96);
    apb(1'b1, 8'h04, 32'h20);
    settle;
    chk(txEmptyReq[0], 1'b0);
    PEER.frame(12'hFFF, 11, seen);
    settle;
    chk(seen[10:0], {1'b1, ^8'h96, 8'h96, 1'b0});
    // cut a frame after three data bits, then drop the transmitter enable
    tcWrite(8'h00);
    settle;
    PEER.frame(12'hFFF, 3, seen);
    settle;
    chk(txdOut[0], 1'b0);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'h005);
    settle;
    chk({txdOeN[0], txdOut[0]}, 2'h1);
    finish_test;
  end
endmodule
